//--- tlic_pkg.sv
// constants, register map and state types for the two-level interrupt controller
package tlic_pkg;

    // program counter and source layout
    localparam int unsigned PC_W     = 21;
    localparam int unsigned NUM_SRC  = 8;
    localparam int unsigned NUM_EXT  = 3;
    localparam int unsigned PORT_W   = 4;
    localparam int unsigned NUM_PER  = 4;
    localparam int unsigned SYNC_W   = NUM_EXT + PORT_W;

    // vector addresses
    localparam logic [PC_W-1:0] VEC_HIGH = 21'h000008;
    localparam logic [PC_W-1:0] VEC_LOW  = 21'h000018;

    // wishbone byte offsets, one 32-bit word each
    localparam logic [7:0] OFS_INTCTL = 8'h00;
    localparam logic [7:0] OFS_RSTCTL = 8'h04;
    localparam logic [7:0] OFS_FLAG   = 8'h08;
    localparam logic [7:0] OFS_ENABLE = 8'h0c;
    localparam logic [7:0] OFS_PRIO   = 8'h10;
    localparam logic [7:0] OFS_MASK   = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;

    // field positions
    localparam int unsigned BIT_HIGH_GIE  = 7;
    localparam int unsigned BIT_LOW_GIE   = 6;
    localparam int unsigned BIT_PRIO_EN   = 7;
    localparam int unsigned BIT_IN_HIGH   = 0;
    localparam int unsigned BIT_IN_LOW    = 1;

    // source index map: 0..2 external pins, 3 port change, 4..7 peripherals
    localparam logic [NUM_SRC-1:0] CORE_SRC_MASK = 8'h0f;
    localparam logic [NUM_SRC-1:0] FIXED_HIGH    = 8'h01;

    // reset values
    localparam logic [NUM_SRC-1:0] PRIO_RST = 8'hff;
    localparam logic [NUM_SRC-1:0] ZERO_RST = 8'h00;

    // input synchroniser state
    typedef struct packed {
        logic [SYNC_W-1:0] meta;
        logic [SYNC_W-1:0] stable;
        logic [SYNC_W-1:0] prev;
    } tlic_sync_t;

    // controller state
    typedef struct packed {
        logic               highGie;
        logic               lowGie;
        logic               priorityLevelsEnable;
        logic [NUM_SRC-1:0] flags;
        logic [NUM_SRC-1:0] enables;
        logic [NUM_SRC-1:0] priorities;
        logic [NUM_SRC-1:0] irqMask;
        logic               inHigh;
        logic               inLow;
        logic               vecLoad;
        logic [PC_W-1:0]    vecAddr;
        logic [PC_W-1:0]    retAddr;
        logic               ack;
        logic [31:0]        rdata;
    } tlic_state_t;

endpackage : tlic_pkg

//--- tlic_pin_events.sv
// two-flop synchroniser and edge detection for external pins and port change inputs
`timescale 1ns/10ps
`default_nettype none
module tlic_pin_events (
    // clock and reset
    input  wire logic                           mclk,
    input  wire logic                           rst,
    // asynchronous pins
    input  wire logic [tlic_pkg::NUM_EXT-1:0]   extPin,
    input  wire logic [tlic_pkg::PORT_W-1:0]    upperPortChangeInput,
    // one-cycle events
    output logic      [tlic_pkg::NUM_EXT-1:0]   extRise,
    output logic                                portChange
);
    import tlic_pkg::*;

    tlic_sync_t st;
    tlic_sync_t nx;

    // meta feeds only stable; edges are taken from stable against prev
    always_comb begin
        nx        = st;
        nx.meta   = {upperPortChangeInput, extPin};
        nx.stable = st.meta;
        nx.prev   = st.stable;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= nx;
        end
    end

    // a pin already high at reset release shows as one rising edge
    assign extRise    = st.stable[NUM_EXT-1:0] & ~st.prev[NUM_EXT-1:0];
    assign portChange = |(st.stable[SYNC_W-1:NUM_EXT] ^ st.prev[SYNC_W-1:NUM_EXT]);

endmodule : tlic_pin_events
`default_nettype wire

//--- tlic_controller.sv
// two-level prioritised interrupt controller with wishbone register access
//
// The placing of the registers and register access over Wishbone are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module tlic_controller (
    // clock and reset
    input  wire logic                           mclk,
    input  wire logic                           rst,
    // wishbone classic slave
    input  wire logic                           wb_cyc_i,
    input  wire logic                           wb_stb_i,
    input  wire logic                           wb_we_i,
    input  wire logic [7:0]                     wb_adr_i,
    input  wire logic [3:0]                     wb_sel_i,
    input  wire logic [31:0]                    wb_dat_i,
    output logic      [31:0]                    wb_dat_o,
    output logic                                wb_ack_o,
    // event sources
    input  wire logic [tlic_pkg::NUM_EXT-1:0]   extPin,
    input  wire logic [tlic_pkg::PORT_W-1:0]    upperPortChangeInput,
    input  wire logic [tlic_pkg::NUM_PER-1:0]   periphEvent,
    // core fetch and stack
    input  wire logic [tlic_pkg::PC_W-1:0]      pcIn,
    input  wire logic                           returnFromInterruptInstruction,
    output logic                                vectorLoad,
    output logic      [tlic_pkg::PC_W-1:0]      vectorAddr,
    output logic                                stackPush,
    output logic      [tlic_pkg::PC_W-1:0]      stackData,
    // interrupt line
    output logic                                irq
);
    import tlic_pkg::*;

    tlic_state_t        st;
    tlic_state_t        nx;
    logic [NUM_EXT-1:0] extRise;
    logic               portChange;
    logic [NUM_SRC-1:0] events;
    logic [NUM_SRC-1:0] pending;
    logic [NUM_SRC-1:0] effPri;
    logic               highReq;
    logic               lowReq;
    logic               busReq;
    logic               busWrite;
    logic               lowReturn;
    logic [31:0]        readMux;

    // pins cross into mclk here; peripherals are already on mclk
    tlic_pin_events u_pin_events (
        .mclk                 (mclk),
        .rst                  (rst),
        .extPin               (extPin),
        .upperPortChangeInput (upperPortChangeInput),
        .extRise              (extRise),
        .portChange           (portChange)
    );

    assign events  = {periphEvent, portChange, extRise};
    assign pending = st.flags & st.enables;
    // external pin zero has no priority bit and is always high level
    assign effPri  = st.priorities | FIXED_HIGH;

    // request qualification per mode
    always_comb begin
        if (st.priorityLevelsEnable) begin
            highReq = st.highGie && |(pending & effPri);
            lowReq  = st.highGie && st.lowGie && |(pending & ~effPri);
        end else begin
            // priority bits play no part; bit 6 only gates peripherals
            highReq = st.highGie && |(pending & (CORE_SRC_MASK | {NUM_SRC{st.lowGie}}));
            lowReq  = 1'b0;
        end
    end

    // the exited level is low only when low is running and high is not
    assign lowReturn = st.priorityLevelsEnable && !st.inHigh && st.inLow;

    // bus decode: request taken on first cycle, write lands on the ack edge
    assign busReq   = wb_cyc_i && wb_stb_i;
    assign busWrite = busReq && wb_we_i && st.ack && wb_sel_i[0];

    // read view; unmapped offsets read zero
    always_comb begin
        readMux = 32'h00000000;
        case (wb_adr_i)
            OFS_INTCTL: begin
                readMux[BIT_HIGH_GIE] = st.highGie;
                readMux[BIT_LOW_GIE]  = st.lowGie;
            end
            OFS_RSTCTL: readMux[BIT_PRIO_EN] = st.priorityLevelsEnable;
            OFS_FLAG:   readMux[NUM_SRC-1:0] = st.flags;
            OFS_ENABLE: readMux[NUM_SRC-1:0] = st.enables;
            OFS_PRIO:   readMux[NUM_SRC-1:0] = effPri;
            OFS_MASK:   readMux[NUM_SRC-1:0] = st.irqMask;
            OFS_STATUS: begin
                readMux[BIT_IN_HIGH] = st.inHigh;
                readMux[BIT_IN_LOW]  = st.inLow;
            end
            default:    readMux = 32'h00000000;
        endcase
    end

    // next state: software writes first, hardware actions override them
    always_comb begin
        nx         = st;
        nx.vecLoad = 1'b0;
        nx.ack     = busReq && !st.ack;
        if (busReq && !st.ack) begin
            nx.rdata = readMux;
        end
        if (busWrite) begin
            case (wb_adr_i)
                OFS_INTCTL: begin
                    nx.highGie = wb_dat_i[BIT_HIGH_GIE];
                    nx.lowGie  = wb_dat_i[BIT_LOW_GIE];
                end
                OFS_RSTCTL: nx.priorityLevelsEnable = wb_dat_i[BIT_PRIO_EN];
                OFS_FLAG:   nx.flags = st.flags & ~wb_dat_i[NUM_SRC-1:0];
                OFS_ENABLE: nx.enables = wb_dat_i[NUM_SRC-1:0];
                OFS_PRIO:   nx.priorities = wb_dat_i[NUM_SRC-1:0];
                OFS_MASK:   nx.irqMask = wb_dat_i[NUM_SRC-1:0];
                default:    nx.enables = st.enables;
            endcase
        end
        // events set flags whatever the enables; set beats a same-cycle clear
        nx.flags = nx.flags | events;
        // high is tested first so it wins a tie and can cut into low service
        if (highReq) begin
            nx.highGie = 1'b0;
            nx.inHigh  = 1'b1;
            nx.vecLoad = 1'b1;
            nx.vecAddr = VEC_HIGH;
            nx.retAddr = pcIn;
        end else if (lowReq) begin
            nx.lowGie  = 1'b0;
            nx.inLow   = 1'b1;
            nx.vecLoad = 1'b1;
            nx.vecAddr = VEC_LOW;
            nx.retAddr = pcIn;
        end else if (returnFromInterruptInstruction) begin
            if (lowReturn) begin
                nx.lowGie = 1'b1;
                nx.inLow  = 1'b0;
            end else begin
                nx.highGie = 1'b1;
                nx.inHigh  = 1'b0;
            end
        end
    end

    // single register stage holds the whole controller state
    always_ff @(posedge mclk) begin
        if (rst) begin
            st            <= '0;
            st.priorities <= PRIO_RST;
            st.irqMask    <= ZERO_RST;
        end else begin
            st <= nx;
        end
    end

    // registered outputs; the vector issues one cycle after qualification
    assign wb_dat_o   = st.rdata;
    assign wb_ack_o   = st.ack;
    assign vectorLoad = st.vecLoad;
    assign vectorAddr = st.vecAddr;
    assign stackPush  = st.vecLoad;
    assign stackData  = st.retAddr;
    // level line for a monitor, separate from the core vectoring path
    assign irq        = |(st.flags & st.irqMask);

    // checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    a_high_vector_go: assert property (highReq |=> vectorLoad && vectorAddr == VEC_HIGH)
        else $error("high request did not vector to the high address");
    a_low_vector_go: assert property (lowReq && !highReq |=> vectorLoad && vectorAddr == VEC_LOW)
        else $error("low request did not vector to the low address");
    a_preempt_low: assert property (st.inLow && highReq |=> st.inHigh && st.inLow && vectorAddr == VEC_HIGH)
        else $error("high request failed to preempt low service");
    a_pin0_fixed: assert property (st.priorityLevelsEnable && st.highGie && pending[0] |-> highReq)
        else $error("external pin zero not treated as high level");
    a_mode_reset: assert property ($past(rst) |-> !st.priorityLevelsEnable && !st.highGie)
        else $error("controller left reset outside compatibility mode");
    a_level_gates: assert property (st.priorityLevelsEnable && !st.lowGie |-> !lowReq)
        else $error("low request raised with low global enable clear");
    a_compat_vector: assert property (!st.priorityLevelsEnable |-> !lowReq)
        else $error("low vector requested in compatibility mode");
    a_periph_gate: assert property (!st.priorityLevelsEnable && !st.lowGie
                                    && (pending & CORE_SRC_MASK) == ZERO_RST |-> !highReq)
        else $error("peripheral source passed a closed peripheral gate");
    a_gie_cleared: assert property (highReq |=> !st.highGie ##1 !st.vecLoad)
        else $error("global enable not cleared on accept");
    a_stack_push: assert property ((highReq || lowReq) |=> stackPush && stackData == $past(pcIn))
        else $error("return address not pushed on accept");
    a_return_gie: assert property (returnFromInterruptInstruction && !highReq && !lowReq
                                   && !lowReturn |=> st.highGie && !st.inHigh)
        else $error("return did not restore the high or single global enable");
    a_pin_latency: assert property ($rose(extPin[1]) |-> ##[2:3] st.flags[1])
        else $error("external pin flag not set within latency");
    a_flag_sticky: assert property (|events |=> (st.flags & $past(events)) == $past(events))
        else $error("event did not set its flag");
    a_high_first: assert property (highReq && (|(pending & ~effPri)) && st.lowGie
                                   |=> vectorAddr == VEC_HIGH)
        else $error("low request served before a same-cycle high request");

    c_high_taken: cover property (highReq ##1 vectorLoad);
    c_low_preempted: cover property (lowReq ##[1:20] highReq);
    c_low_return: cover property (returnFromInterruptInstruction && lowReturn);
    c_compat_periph: cover property (!st.priorityLevelsEnable && highReq && pending[7]);

endmodule : tlic_controller
`default_nettype wire

//--- tlic_core_model.sv
// core fetch and return-stack stand-in facing the controller's vectoring port
`timescale 1ns/10ps
`default_nettype none
module tlic_core_model (
    // clock and reset
    input  wire logic                      mclk,
    input  wire logic                      rst,
    // controller side
    input  wire logic                      stackPush,
    input  wire logic [tlic_pkg::PC_W-1:0] vectorAddr,
    input  wire logic [tlic_pkg::PC_W-1:0] stackData,
    input  wire logic                      retReq,
    output logic      [tlic_pkg::PC_W-1:0] pcIn,
    output logic                           retPulse
);
    import tlic_pkg::*;
    logic [PC_W-1:0] stack [0:15];
    logic [PC_W-1:0] pcReg;
    logic [3:0]      depth;
    assign pcIn = pcReg;
    assign retPulse = retReq; // return issued only when the bench says
    // fetch runs on; a push jumps to the vector, a return pops the stack
    always_ff @(posedge mclk) begin
        if (rst) begin
            pcReg <= 21'h000100;
            depth <= 4'h0;
        end else if (stackPush) begin
            stack[depth] <= stackData;
            depth <= depth + 4'h1;
            pcReg <= vectorAddr;
        end else if (retReq && depth != 4'h0) begin
            depth <= depth - 4'h1;
            pcReg <= stack[depth-4'h1];
        end else begin
            pcReg <= pcReg + 21'h1;
        end
    end
endmodule : tlic_core_model
`default_nettype wire

//--- two_level_interrupt_controller_tb_top.sv
// self-checking bench for the two-level interrupt controller
`timescale 1ns/10ps
`default_nettype none
module two_level_interrupt_controller_tb_top;
    import tlic_pkg::*;
    logic        mclk = 1'b0;
    logic        rst, cyc, stb, we, ack, retReq, ret, vecLd, push, irq;
    logic [7:0]  adr;
    logic [3:0]  sel, upc, per;
    logic [31:0] dat, datO;
    logic [2:0]  ext;
    logic [20:0] pcIn, vecAd, stkD;
    int          failures = 0;
    int          checks = 0;

    always #12.5 mclk = ~mclk;

    tlic_controller i_dut (.mclk(mclk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(datO),
        .wb_ack_o(ack), .extPin(ext), .upperPortChangeInput(upc), .periphEvent(per),
        .pcIn(pcIn), .returnFromInterruptInstruction(ret), .vectorLoad(vecLd),
        .vectorAddr(vecAd), .stackPush(push), .stackData(stkD), .irq(irq));
    tlic_core_model i_core (.mclk(mclk), .rst(rst), .stackPush(push), .vectorAddr(vecAd),
        .stackData(stkD), .retReq(retReq), .pcIn(pcIn), .retPulse(ret));

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one classic cycle; held until ack is sampled, then one idle cycle
    // every register update is one access on byte lane 0 only (sel 4'h1), never a two-step move
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [31:0] q);
        int n;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'h1;
        dat <= {24'h0, d};
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (ack !== 1'b1 && n < 16);
        q = datO;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (ack !== 1'b1) begin
            failures++;
            test_done();
        end
        @(posedge mclk);
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 8'h00, q);
        chk(q, exp);
    endtask : rd

    task automatic pulse(input logic [3:0] b);
        per <= b;
        @(posedge mclk);
        per <= 4'h0;
    endtask : pulse

    task automatic do_ret();
        retReq <= 1'b1;
        @(posedge mclk);
        retReq <= 1'b0;
        @(posedge mclk);
    endtask : do_ret

    task automatic no_vec();
        repeat (8) begin
            @(posedge mclk);
            chk({31'h0, vecLd}, 32'h0);
        end
    endtask : no_vec

    // bounded wait for a vector load; lat is one less than the edges counted from call to the load
    task automatic wait_vec(input logic [20:0] exp, output int lat);
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (vecLd !== 1'b1 && n < 24);
        if (vecLd !== 1'b1) begin
            failures++;
            test_done();
        end
        chk({11'h0, vecAd}, {11'h0, exp});
        chk({31'h0, push}, 32'h1);
        chk({11'h0, stkD}, {11'h0, pcIn - 21'h1});
        lat = n - 1;
    endtask : wait_vec

    task automatic t_reset();
        rd(OFS_PRIO, 32'hff);
        rd(OFS_RSTCTL, 32'h0);
        rd(OFS_INTCTL, 32'h0);
        rd(8'h40, 32'h0);
    endtask : t_reset

    task automatic t_compat();
        int l;
        wr(OFS_ENABLE, 8'h10);
        wr(OFS_PRIO, 8'h00);
        wr(OFS_INTCTL, 8'h80);
        pulse(4'h1);
        no_vec();
        wr(OFS_INTCTL, 8'hc0);
        wait_vec(VEC_HIGH, l);
        rd(OFS_INTCTL, 32'h40);
        wr(OFS_FLAG, 8'h10);
        do_ret();
        rd(OFS_INTCTL, 32'hc0);
    endtask : t_compat

    task automatic t_prio();
        int l;
        wr(OFS_RSTCTL, 8'h80);
        wr(OFS_PRIO, 8'h20);
        rd(OFS_PRIO, 32'h21);
        wr(OFS_ENABLE, 8'h3a);
        pulse(4'h1);
        wait_vec(VEC_LOW, l);
        rd(OFS_INTCTL, 32'h80);
        pulse(4'h2);
        wait_vec(VEC_HIGH, l);
        rd(OFS_STATUS, 32'h3);
        wr(OFS_FLAG, 8'h30);
        do_ret();
        rd(OFS_INTCTL, 32'h80);
        do_ret();
        rd(OFS_INTCTL, 32'hc0);
        wr(OFS_INTCTL, 8'h80);
        pulse(4'h1);
        no_vec();
        wr(OFS_FLAG, 8'h10);
        wr(OFS_INTCTL, 8'hc0);
        pulse(4'h3);
        wait_vec(VEC_HIGH, l);
        no_vec();
        wr(OFS_FLAG, 8'h30);
        do_ret();
    endtask : t_prio

    // pin one and port change are low level; pin zero has no priority bit and stays high
    task automatic t_pins();
        int l;
        wr(OFS_ENABLE, 8'h3b);
        for (int s = 0; s < 3; s++) begin
            if (s == 0) begin
                ext <= 3'h2;
            end else if (s == 1) begin
                upc <= 4'h4;
            end else begin
                ext <= 3'h3;
            end
            wait_vec((s == 2) ? VEC_HIGH : VEC_LOW, l);
            chk({31'h0, l >= 3 && l <= 4}, 32'h1);
            wr(OFS_FLAG, 8'h0b);
            do_ret();
        end
    endtask : t_pins

    task automatic t_flags();
        wr(OFS_ENABLE, 8'h00);
        wr(OFS_MASK, 8'h40);
        pulse(4'h8);
        rd(OFS_FLAG, 32'h80);
        chk({31'h0, irq}, 32'h0);
        pulse(4'h4);
        no_vec();
        chk({31'h0, irq}, 32'h1);
        wr(OFS_FLAG, 8'hc0);
        chk({31'h0, irq}, 32'h0);
    endtask : t_flags

    initial begin
        {rst, cyc, stb, we, retReq, adr, sel, dat, ext, upc, per} = '0;
        rst = 1'b1;
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        t_reset();
        t_compat();
        t_prio();
        t_pins();
        t_flags();
        test_done();
    end
endmodule : two_level_interrupt_controller_tb_top
`default_nettype wire
